/* hw/comc_pkg.sv */
// constants for the clock output mux control block
// assumes one 200 MHz clock and an external serial byte engine
package comc_pkg;
  localparam logic [7:0] ADDR_CLOCK_OUTPUT_THREE_RUN = 8'h21;
  localparam logic [7:0] ADDR_RESERVED = 8'h22;
  localparam logic [7:0] ADDR_SRC_SEL = 8'h23;
  localparam logic [7:0] ADDR_PWR_RUN = 8'h24;
  localparam logic [7:0] RST_CLOCK_OUTPUT_THREE_RUN = 8'h80;
  localparam logic [7:0] RST_RESERVED = 8'hF4;
  localparam logic [7:0] RST_SRC_SEL = 8'h8D;
  localparam logic [7:0] RST_PWR_RUN = 8'h9B;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int POS_CLOCK_OUTPUT_THREE_STOPPABLE = 7;
  localparam int POS_CLOCK_OUTPUT_THREE_SEL = 6;
  localparam int POS_CLOCK_OUTPUT_TWO_SEL = 4;
  localparam int POS_CLOCK_OUTPUT_ONE_SEL = 2;
  localparam int POS_DIVIDER_ONE_SEL = 0;
  localparam int POS_POWER_N = 7;
  localparam int POS_REF_FREE_RUN = 6;
  localparam int POS_FREE_RUN_CFG = 5;
  localparam int POS_CLOCK_OUTPUT_ONE_STOPPABLE = 3;
  localparam int POS_OE_FUNC_ON = 2;
  localparam int POS_DIVIDER_FOUR_SEL = 0;
  localparam int NUM_CHAN = 5;
  localparam int CH_CLOCK_OUTPUT_ONE = 0;
  localparam int CH_CLOCK_OUTPUT_TWO = 1;
  localparam int CH_CLOCK_OUTPUT_THREE = 2;
  localparam int CH_DIVIDER_ONE = 3;
  localparam int CH_DIVIDER_FOUR = 4;
  localparam int NUM_PIN = 14;
  localparam int PIN_DIVIDER_THREE = 0;
  localparam int PIN_DIVIDER_FIVE = 1;
  localparam int PIN_DIVIDER_ONE = 2;
  localparam int PIN_LOW_RATE = 3;
  localparam int PIN_LOOP1 = 4;
  localparam int PIN_REF = 5;
  localparam int PIN_DIVIDER_FOUR_SEED = 6;
  localparam int PIN_LOOP2_CH2 = 7;
  localparam int PIN_LOOP3_CH2 = 8;
  localparam int PIN_DIVIDER_THREE_SEED = 9;
  localparam int PIN_DIVIDER_FIVE_SEED = 10;
  localparam int PIN_STOP_REQ = 11;
  localparam int PIN_OE_TWO = 12;
  localparam int PIN_OE_THREE = 13;
  typedef enum logic [1:0] {
    COMC_RUN = 2'b00,
    COMC_DRAIN = 2'b01,
    COMC_ALIGN = 2'b10
  } comc_chan_state_t;
endpackage

/* hw/comc_clock_output_mux_control.sv */
// control bytes, source muxes and run control for three clock outputs
// assumes a byte engine on mclk; clock and pin inputs are asynchronous
//
// How it works
// - third output stoppable only when its bit set
// - output selects: divider3, divider5, divider1, low-rate
// - select fields at 7:6, 5:4, 3:2
// - divider-one source: loop, reference, divider-four seed
// - power bit cleared drives power-down pin low, stops output one and both divider sources
// - reference free run on output two
// - config bit adds output three to free run
// - first output stoppable only when its bit set
// - extra output-enable pins honoured only when enabled
// - divider-four source: two channels or two seeds
`timescale 1ns/1ps
module comc_clock_output_mux_control
  import comc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic dividerThreeClock,
  input wire logic dividerFiveClock,
  input wire logic dividerOneClock,
  input wire logic lowRateOscillatorClock,
  input wire logic firstSynthLoopClock,
  input wire logic referenceClock,
  input wire logic dividerFourSeedClock,
  input wire logic secondLoopChannelTwo,
  input wire logic thirdLoopChannelTwo,
  input wire logic dividerThreeSeedClock,
  input wire logic dividerFiveSeedClock,
  input wire logic clockStopRequest,
  input wire logic outputEnableTwo,
  input wire logic outputEnableThree,
  output logic clockOutputOne,
  output logic clockOutputTwo,
  output logic clockOutputThree,
  output logic dividerOneSource,
  output logic dividerFourSource,
  output logic chipPowerDownN
);

  logic [7:0] outputThreeRunControl;
  logic [7:0] reservedControlByte;
  logic [7:0] outputSourceSelect;
  logic [7:0] powerAndRunControl;
  logic [7:0] next_outputThreeRunControl;
  logic [7:0] next_reservedControlByte;
  logic [7:0] next_outputSourceSelect;
  logic [7:0] next_powerAndRunControl;
  logic [7:0] next_regRdData;
  logic next_chipPowerDownN;

  logic [NUM_PIN-1:0] pinRaw;
  logic [NUM_PIN-1:0] pinS1;
  logic [NUM_PIN-1:0] pinS2;
  logic [NUM_PIN-1:0] pinS3;
  logic [NUM_PIN-1:0] pinStable;
  logic [NUM_PIN-1:0] next_pinStable;

  logic [NUM_CHAN-1:0] chanOut;

  // requested source index of one channel
  function automatic logic [1:0] reqSelect(input int ch, input logic [7:0] srcSel, input logic [7:0] pwrRun);
    logic [1:0] sel;
    sel = 2'b00;
    case (ch)
      CH_CLOCK_OUTPUT_ONE: sel = srcSel[POS_CLOCK_OUTPUT_ONE_SEL +: 2];
      CH_CLOCK_OUTPUT_TWO: sel = srcSel[POS_CLOCK_OUTPUT_TWO_SEL +: 2];
      CH_CLOCK_OUTPUT_THREE: sel = srcSel[POS_CLOCK_OUTPUT_THREE_SEL +: 2];
      CH_DIVIDER_ONE: sel = srcSel[POS_DIVIDER_ONE_SEL +: 2];
      CH_DIVIDER_FOUR: sel = pwrRun[POS_DIVIDER_FOUR_SEL +: 2];
      default: sel = 2'b00;
    endcase
    return sel;
  endfunction

  // four candidate sources of one channel, indexed by select code
  function automatic logic [3:0] chanSources(input int ch, input logic [NUM_PIN-1:0] pins);
    logic [3:0] src;
    src = 4'h0;
    case (ch)
      CH_CLOCK_OUTPUT_ONE, CH_CLOCK_OUTPUT_TWO, CH_CLOCK_OUTPUT_THREE:
        src = {pins[PIN_LOW_RATE], pins[PIN_DIVIDER_ONE], pins[PIN_DIVIDER_FIVE], pins[PIN_DIVIDER_THREE]};
      CH_DIVIDER_ONE:
        src = {pins[PIN_DIVIDER_FOUR_SEED], pins[PIN_DIVIDER_FOUR_SEED], pins[PIN_REF], pins[PIN_LOOP1]};
      CH_DIVIDER_FOUR:
        src = {pins[PIN_DIVIDER_FIVE_SEED], pins[PIN_DIVIDER_THREE_SEED], pins[PIN_LOOP3_CH2], pins[PIN_LOOP2_CH2]};
      default:
        src = 4'h0;
    endcase
    return src;
  endfunction

  // whether a channel may pass its clock now
  function automatic logic gateWanted(input int ch, input logic [7:0] o3Run, input logic [7:0] pwrRun,
                                      input logic [NUM_PIN-1:0] pins);
    logic powered;
    logic refRun;
    logic oeOn;
    logic want;
    powered = pwrRun[POS_POWER_N];
    refRun = pwrRun[POS_REF_FREE_RUN];
    oeOn = pwrRun[POS_OE_FUNC_ON];
    want = 1'b0;
    case (ch)
      CH_CLOCK_OUTPUT_ONE:
        want = powered && !(pwrRun[POS_CLOCK_OUTPUT_ONE_STOPPABLE] && pins[PIN_STOP_REQ]);
      CH_CLOCK_OUTPUT_TWO:
        want = (powered || refRun) && !(oeOn && !pins[PIN_OE_TWO]);
      CH_CLOCK_OUTPUT_THREE:
        want = (powered || (refRun && pwrRun[POS_FREE_RUN_CFG]))
          && !(o3Run[POS_CLOCK_OUTPUT_THREE_STOPPABLE] && pins[PIN_STOP_REQ])
          && !(oeOn && !pins[PIN_OE_THREE]);
      CH_DIVIDER_ONE, CH_DIVIDER_FOUR:
        want = powered;
      default:
        want = 1'b0;
    endcase
    return want;
  endfunction

  // registers, read port and power flag
  always_comb
  begin
    next_outputThreeRunControl = outputThreeRunControl;
    next_reservedControlByte = reservedControlByte;
    next_outputSourceSelect = outputSourceSelect;
    next_powerAndRunControl = powerAndRunControl;
    next_regRdData = regRdData;
    if (regWrite)
    begin
      case (regAddr)
        ADDR_CLOCK_OUTPUT_THREE_RUN: next_outputThreeRunControl = regWrData;
        ADDR_RESERVED: next_reservedControlByte = regWrData;
        ADDR_SRC_SEL: next_outputSourceSelect = regWrData;
        ADDR_PWR_RUN: next_powerAndRunControl = regWrData;
        default: next_reservedControlByte = reservedControlByte;
      endcase
    end
    if (regRead)
    begin
      case (regAddr)
        ADDR_CLOCK_OUTPUT_THREE_RUN: next_regRdData = outputThreeRunControl;
        ADDR_RESERVED: next_regRdData = reservedControlByte;
        ADDR_SRC_SEL: next_regRdData = outputSourceSelect;
        ADDR_PWR_RUN: next_regRdData = powerAndRunControl;
        default: next_regRdData = READ_UNMAPPED;
      endcase
    end
    next_chipPowerDownN = next_powerAndRunControl[POS_POWER_N];
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      outputThreeRunControl <= RST_CLOCK_OUTPUT_THREE_RUN;
      reservedControlByte <= RST_RESERVED;
      outputSourceSelect <= RST_SRC_SEL;
      powerAndRunControl <= RST_PWR_RUN;
      regRdData <= READ_UNMAPPED;
      chipPowerDownN <= 1'b1;
    end
    else if (ce)
    begin
      outputThreeRunControl <= next_outputThreeRunControl;
      reservedControlByte <= next_reservedControlByte;
      outputSourceSelect <= next_outputSourceSelect;
      powerAndRunControl <= next_powerAndRunControl;
      regRdData <= next_regRdData;
      chipPowerDownN <= next_chipPowerDownN;
    end
  end

  // input synchronisers: a change counts once stages two and three agree
  assign pinRaw[PIN_DIVIDER_THREE] = dividerThreeClock;
  assign pinRaw[PIN_DIVIDER_FIVE] = dividerFiveClock;
  assign pinRaw[PIN_DIVIDER_ONE] = dividerOneClock;
  assign pinRaw[PIN_LOW_RATE] = lowRateOscillatorClock;
  assign pinRaw[PIN_LOOP1] = firstSynthLoopClock;
  assign pinRaw[PIN_REF] = referenceClock;
  assign pinRaw[PIN_DIVIDER_FOUR_SEED] = dividerFourSeedClock;
  assign pinRaw[PIN_LOOP2_CH2] = secondLoopChannelTwo;
  assign pinRaw[PIN_LOOP3_CH2] = thirdLoopChannelTwo;
  assign pinRaw[PIN_DIVIDER_THREE_SEED] = dividerThreeSeedClock;
  assign pinRaw[PIN_DIVIDER_FIVE_SEED] = dividerFiveSeedClock;
  assign pinRaw[PIN_STOP_REQ] = clockStopRequest;
  assign pinRaw[PIN_OE_TWO] = outputEnableTwo;
  assign pinRaw[PIN_OE_THREE] = outputEnableThree;

  always_comb
  begin
    next_pinStable = pinStable;
    for (int i = 0; i < NUM_PIN; i++)
    begin
      if (pinS2[i] == pinS3[i])
      begin
        next_pinStable[i] = pinS3[i];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pinS1 <= '0;
      pinS2 <= '0;
      pinS3 <= '0;
      pinStable <= '0;
    end
    else if (ce)
    begin
      pinS1 <= pinRaw;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      pinStable <= next_pinStable;
    end
  end

  // one glitch-free switch per channel
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : gChan
    comc_chan_state_t state;
    comc_chan_state_t next_state;
    logic [1:0] curSel;
    logic [1:0] next_curSel;
    logic gate;
    logic next_gate;
    logic out;
    logic next_out;

    always_comb
    begin
      logic [3:0] src;
      logic [1:0] req;
      logic want;
      logic lvl;
      src = chanSources(c, pinStable);
      req = reqSelect(c, outputSourceSelect, powerAndRunControl);
      want = gateWanted(c, outputThreeRunControl, powerAndRunControl, pinStable);
      lvl = src[curSel];
      next_state = state;
      next_curSel = curSel;
      next_gate = gate;
      next_out = out;
      case (state)
        COMC_RUN:
        begin
          next_out = lvl & gate;
          if (!lvl)
          begin
            next_gate = want; // stop and start only while low
          end
          if (req != curSel)
          begin
            next_state = COMC_DRAIN;
          end
        end
        COMC_DRAIN:
        begin
          // finish the current high phase before leaving the old source
          if (!lvl || !gate)
          begin
            next_out = 1'b0;
            next_curSel = req;
            next_state = COMC_ALIGN;
          end
          else
          begin
            next_out = lvl;
          end
        end
        COMC_ALIGN:
        begin
          // hold low until the new source is low, so its first high is whole
          next_out = 1'b0;
          if (!lvl)
          begin
            next_gate = want;
            next_state = COMC_RUN;
          end
        end
        default:
        begin
          next_out = 1'b0;
          next_state = COMC_RUN;
        end
      endcase
    end

    always_ff @(posedge mclk)
    begin
      if (!rstn)
      begin
        state <= COMC_ALIGN;
        curSel <= 2'b00;
        gate <= 1'b0;
        out <= 1'b0;
      end
      else if (ce)
      begin
        state <= next_state;
        curSel <= next_curSel;
        gate <= next_gate;
        out <= next_out;
      end
    end

    assign chanOut[c] = out;
  end

  assign clockOutputOne = chanOut[CH_CLOCK_OUTPUT_ONE];
  assign clockOutputTwo = chanOut[CH_CLOCK_OUTPUT_TWO];
  assign clockOutputThree = chanOut[CH_CLOCK_OUTPUT_THREE];
  assign dividerOneSource = chanOut[CH_DIVIDER_ONE];
  assign dividerFourSource = chanOut[CH_DIVIDER_FOUR];

endmodule

/* dv/comc_mux_props.sv */
// port assertions for the clock output mux control block
// assumes bench sources with half periods of eight mclk cycles or more
`timescale 1ns/1ps
module comc_mux_props
  import comc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic dividerThreeClock,
  input wire logic dividerFiveClock,
  input wire logic dividerOneClock,
  input wire logic lowRateOscillatorClock,
  input wire logic clockOutputOne,
  input wire logic clockOutputTwo,
  input wire logic clockOutputThree,
  input wire logic dividerOneSource,
  input wire logic dividerFourSource,
  input wire logic chipPowerDownN
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [7:0] pdCnt;
  logic [7:0] candHist;
  // cycles spent powered down, saturating
  always_ff @(posedge mclk)
    pdCnt <= (!rstn || chipPowerDownN) ? 8'h00 : pdCnt + {7'h00, pdCnt != 8'hFF};
  always_ff @(posedge mclk)
    candHist <= {candHist[6:0], dividerThreeClock | dividerFiveClock | dividerOneClock | lowRateOscillatorClock};
  property p_pwr;
    logic v;
    (ce && regWrite && regAddr == ADDR_PWR_RUN, v = regWrData[POS_POWER_N])
      ##1 (ce && !(regWrite && regAddr == ADDR_PWR_RUN)) [*3] |-> chipPowerDownN == v;
  endproperty
  AST_RESET_STATE: assert property ($rose(rstn) |-> chipPowerDownN && !clockOutputOne && regRdData == 8'h00)
    else $error("state after reset wrong");
  AST_WRITE_READ: assert property ((ce && regWrite && regAddr == ADDR_SRC_SEL ##1 !regWrite [*2]
    ##1 ce && regRead && regAddr == ADDR_SRC_SEL) |=> regRdData == $past(regWrData, 4))
    else $error("select byte read back wrong");
  AST_READ_HOLD: assert property (!(ce && regRead) |=> $stable(regRdData))
    else $error("read data moved without a read");
  AST_POWER_BIT: assert property (p_pwr)
    else $error("power bit not on its pin");
  AST_POWER_STOP: assert property (pdCnt >= 8'd200 |-> !clockOutputOne && !dividerOneSource && !dividerFourSource)
    else $error("clock runs while powered down");
  AST_FOLLOW: assert property ($rose(clockOutputOne) || $rose(clockOutputTwo) || $rose(clockOutputThree)
    |-> |candHist[7:2])
    else $error("output rose with no source high");
  AST_NO_RUNT: assert property ($rose(clockOutputOne) |=> clockOutputOne [*3])
    else $error("short high phase on output one");
  AST_CE_FREEZE: assert property (!ce |=> $stable(regRdData) && $stable(chipPowerDownN) && $stable(clockOutputTwo))
    else $error("state moved with enable low");
  cover property (ce && regWrite && regAddr == ADDR_PWR_RUN && !regWrData[POS_POWER_N]);
  cover property (pdCnt == 8'd200);
  cover property ($rose(clockOutputThree));
endmodule
bind comc_clock_output_mux_control comc_mux_props i_props (.mclk(mclk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
  .dividerThreeClock(dividerThreeClock), .dividerFiveClock(dividerFiveClock), .dividerOneClock(dividerOneClock),
  .lowRateOscillatorClock(lowRateOscillatorClock), .clockOutputOne(clockOutputOne), .clockOutputTwo(clockOutputTwo),
  .clockOutputThree(clockOutputThree), .dividerOneSource(dividerOneSource), .dividerFourSource(dividerFourSource),
  .chipPowerDownN(chipPowerDownN));

/* dv/comc_host_model.sv */
// host side of the byte register port: single byte transfers
// assumes strobes taken on rising mclk, read data valid one cycle later
`timescale 1ns/1ps
module comc_host_model
(
  input wire logic mclk,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWrData
);
  initial
  begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWrData = 8'h00;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= w;
    regRead <= !w;
    @(posedge mclk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    @(posedge mclk);
    q = regRdData;
  endtask
  // bits outside the mask keep what was read
  task automatic rmw(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v, output logic [7:0] q,
    output logic [7:0] n);
    logic [7:0] t;
    xfer(1'b0, a, 8'h00, q);
    xfer(1'b1, a, (q & ~m) | (v & m), t);
    xfer(1'b0, a, 8'h00, n);
  endtask
endmodule

/* dv/comc_clock_output_mux_control_tb_top.sv */
// self-checking bench for the clock output mux control block
// assumes every source is a counter bit, so each rate is known
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: %h %h", $time, a, b); end end
module comc_clock_output_mux_control_tb_top;
  import comc_pkg::*;
  logic mclk, rstn, ce, stopReq, oeTwo, oeThree, pdn, regWrite, regRead;
  logic [7:0] regAddr, regWrData, regRdData, q, n, m, v;
  logic [7:0] cnt = 8'h00;
  logic [4:0] outs, prev;
  logic [7:0] mdl [4];
  int errors, cmp_count, cyc, seed, s, x;
  int ec [5];
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) cnt <= cnt + 8'h01;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      errors++;
      end_of_test();
    end
  end
  comc_host_model i_host (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWrData(regWrData));
  comc_clock_output_mux_control i_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData), .dividerThreeClock(cnt[3]),
    .dividerFiveClock(cnt[4]), .dividerOneClock(cnt[5]), .lowRateOscillatorClock(cnt[6]),
    .firstSynthLoopClock(cnt[3]), .referenceClock(cnt[4]), .dividerFourSeedClock(cnt[5]),
    .secondLoopChannelTwo(cnt[3]), .thirdLoopChannelTwo(cnt[4]), .dividerThreeSeedClock(cnt[5]),
    .dividerFiveSeedClock(cnt[6]), .clockStopRequest(stopReq), .outputEnableTwo(oeTwo),
    .outputEnableThree(oeThree), .clockOutputOne(outs[0]), .clockOutputTwo(outs[1]), .clockOutputThree(outs[2]),
    .dividerOneSource(outs[3]), .dividerFourSource(outs[4]), .chipPowerDownN(pdn));
  // rising edges per 512 cycles for each output
  function automatic int expv(int i);
    logic [7:0] a, c, p;
    a = mdl[0];
    c = mdl[2];
    p = mdl[3];
    case (i)
      0: return (p[7] && !(stopReq && p[3])) ? 32 >> c[3:2] : 0;
      1: return ((p[7] || p[6]) && !(p[2] && !oeTwo)) ? 32 >> c[5:4] : 0;
      2: return ((p[7] || (p[6] && p[5])) && !(stopReq && a[7]) && !(p[2] && !oeThree)) ? 32 >> c[7:6] : 0;
      3: return p[7] ? (c[1] ? 8 : 32 >> c[0]) : 0;
      default: return p[7] ? 32 >> p[1:0] : 0;
    endcase
  endfunction
  task automatic measure();
    repeat (300) @(posedge mclk);
    #1;
    ec = '{default: 0};
    prev = outs;
    repeat (512)
    begin
      @(posedge mclk);
      #1;
      for (int i = 0; i < 5; i++) ec[i] += int'(outs[i] && !prev[i]);
      prev = outs;
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    stopReq = 1'b0;
    oeTwo = 1'b1;
    oeThree = 1'b1;
    seed = 86;
    mdl = '{RST_CLOCK_OUTPUT_THREE_RUN, RST_RESERVED, RST_SRC_SEL, RST_PWR_RUN};
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a < 5; a++)
    begin
      i_host.xfer(1'b0, ADDR_CLOCK_OUTPUT_THREE_RUN + 8'(a), 8'h00, q);
      `CHK(q, (a < 4) ? mdl[a] : READ_UNMAPPED)
    end
    i_host.xfer(1'b1, 8'h25, 8'hFF, q);
    ce <= 1'b0;
    i_host.xfer(1'b1, ADDR_PWR_RUN, 8'h00, q);
    ce <= 1'b1;
    i_host.xfer(1'b0, 8'h25, 8'h00, q);
    `CHK(q, READ_UNMAPPED)
    i_host.xfer(1'b0, ADDR_PWR_RUN, 8'h00, q);
    `CHK(q, mdl[3])
    for (int k = 0; k < 40; k++)
    begin
      measure();
      for (int i = 0; i < 5; i++) `CHK((ec[i] - expv(i)) inside {[-1:1]}, 1'b1)
      `CHK(pdn, mdl[3][7])
      for (int j = 0; j < 3; j++)
      begin
        s = $random(seed);
        x = j + int'(j > 0);
        m = (j == 0) ? 8'h80 : (j == 1) ? 8'hFF : 8'hEF;
        v = s[7:0] | ((j == 2 && k[1]) ? 8'h80 : 8'h00);
        i_host.rmw(ADDR_CLOCK_OUTPUT_THREE_RUN + 8'(x), m, v, q, n);
        `CHK(q, mdl[x])
        mdl[x] = (mdl[x] & ~m) | (v & m);
        `CHK(n, mdl[x])
      end
      stopReq <= s[8];
      oeTwo <= s[9];
      oeThree <= s[10];
    end
    end_of_test();
  end
endmodule
